/* logic/cardbus_window_decode.v */
// Purpose: Window registers and forwarding decode of a PCI-to-CardBus bridge function
// Assumes: One clock, synchronous active-high reset, AHB-Lite single word transfers
// Notes:   Decode outputs are registered, one cycle after the address is presented
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cardbus_window_map.vh"

module cardbus_window_decode
(
  input  wire        clk,
  input  wire        srst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        pci_valid,
  input  wire        pci_is_io,
  input  wire [31:0] pci_addr,
  output reg         pci_to_cardbus,
  output reg         pci_prefetchable,
  input  wire        cb_valid,
  input  wire        cb_is_io,
  input  wire [31:0] cb_addr,
  output reg         cardbus_to_pci
);

  reg  [31:0] mem_window0_start;
  reg  [31:0] mem_window0_end;
  reg  [31:0] mem_window1_start;
  reg  [31:0] mem_window1_end;
  reg  [31:0] io_window0_start;
  reg  [31:0] io_window0_end;
  reg  [31:0] io_window1_start;
  reg  [31:0] io_window1_end;
  reg         mem_win0_prefetchable;
  reg         mem_win1_prefetchable;
  reg         wr_pending;
  reg  [7:0]  wr_addr;
  reg  [31:0] next_rdata;
  wire        take;
  wire [3:0]  pci_hits;
  wire [3:0]  cb_hits;
  wire [31:0] status_word;
  wire        pci_type_hit;
  wire        cb_type_hit;
  wire        next_pci_to_cardbus;
  wire        next_pci_prefetchable;
  wire        next_cardbus_to_pci;

  // Reset word as a constant so single prefetch bits can be picked out
  localparam [31:0] CTRL_INIT = `CTRL_RESET;

  // Replaces only the writable bits
  function [31:0] masked_write;
    input [31:0] old_value;
    input [31:0] new_value;
    input [31:0] mask;
    begin
      masked_write = (old_value & ~mask) | (new_value & mask);
    end
  endfunction

  // Hit of the window pair that matches the cycle's type
  function type_hit;
    input       is_io;
    input [3:0] hits;
    begin
      if (is_io)
        type_hit = hits[2] | hits[3];
      else
        type_hit = hits[0] | hits[1];
    end
  endfunction

  // Window 0 wins when both memory windows claim the address
  function pref_pick;
    input [1:0] mem_hits;
    input       pref0;
    input       pref1;
    begin
      if (mem_hits[0])
        pref_pick = pref0;
      else
        pref_pick = mem_hits[1] & pref1;
    end
  endfunction

  // Slave never stalls; every access completes OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && hready && htrans[1];

  always @(posedge clk)
  begin
    if (srst)
    begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
    end
    else if (hready)
    begin
      wr_pending <= take && hwrite;
      wr_addr    <= haddr[7:0];
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      mem_window0_start     <= `WINDOW_RESET;
      mem_window0_end       <= `WINDOW_RESET;
      mem_window1_start     <= `WINDOW_RESET;
      mem_window1_end       <= `WINDOW_RESET;
      io_window0_start      <= `WINDOW_RESET;
      io_window0_end        <= `WINDOW_RESET;
      io_window1_start      <= `WINDOW_RESET;
      io_window1_end        <= `WINDOW_RESET;
      mem_win0_prefetchable <= CTRL_INIT[`CTRL_MEM_WIN0_PREFETCHABLE_BIT];
      mem_win1_prefetchable <= CTRL_INIT[`CTRL_MEM_WIN1_PREFETCHABLE_BIT];
    end
    else if (wr_pending)
    begin
      case (wr_addr)
        `MEM_WINDOW0_START_OFS:
          mem_window0_start <= masked_write(mem_window0_start, hwdata, `MEM_WR_MASK);
        `MEM_WINDOW1_START_OFS:
          mem_window1_start <= masked_write(mem_window1_start, hwdata, `MEM_WR_MASK);
        `MEM_WINDOW0_END_OFS:
          mem_window0_end <= masked_write(mem_window0_end, hwdata, `MEM_WR_MASK);
        `MEM_WINDOW1_END_OFS:
          mem_window1_end <= masked_write(mem_window1_end, hwdata, `MEM_WR_MASK);
        `IO_WINDOW0_START_OFS:
          io_window0_start <= masked_write(io_window0_start, hwdata, `IO_START_WR_MASK);
        `IO_WINDOW1_START_OFS:
          io_window1_start <= masked_write(io_window1_start, hwdata, `IO_START_WR_MASK);
        `IO_WINDOW0_END_OFS:
          io_window0_end <= masked_write(io_window0_end, hwdata, `IO_END_WR_MASK);
        `IO_WINDOW1_END_OFS:
          io_window1_end <= masked_write(io_window1_end, hwdata, `IO_END_WR_MASK);
        `WINDOW_CTRL_OFS:
        begin
          mem_win0_prefetchable <= hwdata[`CTRL_MEM_WIN0_PREFETCHABLE_BIT];
          mem_win1_prefetchable <= hwdata[`CTRL_MEM_WIN1_PREFETCHABLE_BIT];
        end
        default:
        begin
          mem_win0_prefetchable <= mem_win0_prefetchable;
        end
      endcase
    end
  end

  // Live hits, so a read shows the addresses of its own address phase
  assign status_word = {24'h000000, cb_hits, pci_hits};

  always @*
  begin
    next_rdata = 32'h00000000;
    case (haddr[7:0])
      `MEM_WINDOW0_START_OFS: next_rdata = mem_window0_start;
      `MEM_WINDOW0_END_OFS:   next_rdata = mem_window0_end;
      `MEM_WINDOW1_START_OFS: next_rdata = mem_window1_start;
      `MEM_WINDOW1_END_OFS:   next_rdata = mem_window1_end;
      `IO_WINDOW0_START_OFS:  next_rdata = io_window0_start;
      `IO_WINDOW0_END_OFS:    next_rdata = io_window0_end;
      `IO_WINDOW1_START_OFS:  next_rdata = io_window1_start;
      `IO_WINDOW1_END_OFS:    next_rdata = io_window1_end;
      `WINDOW_CTRL_OFS:
        next_rdata = {22'h000000, mem_win1_prefetchable, mem_win0_prefetchable, 8'h00};
      `WINDOW_STATUS_OFS:     next_rdata = status_word;
      default:                next_rdata = 32'h00000000;
    endcase
  end

  // Read data latched at the address phase; a write to the same word is not forwarded
  always @(posedge clk)
  begin
    if (srst)
      hrdata <= 32'h00000000;
    else if (take && !hwrite)
      hrdata <= next_rdata;
  end

  mem_window_match u_pci_mem0
  (
    .start_addr (mem_window0_start),
    .end_addr   (mem_window0_end),
    .addr       (pci_addr),
    .hit        (pci_hits[0])
  );

  mem_window_match u_pci_mem1
  (
    .start_addr (mem_window1_start),
    .end_addr   (mem_window1_end),
    .addr       (pci_addr),
    .hit        (pci_hits[1])
  );

  io_window_match u_pci_io0
  (
    .start_addr (io_window0_start),
    .end_addr   (io_window0_end),
    .addr       (pci_addr),
    .hit        (pci_hits[2])
  );

  io_window_match u_pci_io1
  (
    .start_addr (io_window1_start),
    .end_addr   (io_window1_end),
    .addr       (pci_addr),
    .hit        (pci_hits[3])
  );

  mem_window_match u_cb_mem0
  (
    .start_addr (mem_window0_start),
    .end_addr   (mem_window0_end),
    .addr       (cb_addr),
    .hit        (cb_hits[0])
  );

  mem_window_match u_cb_mem1
  (
    .start_addr (mem_window1_start),
    .end_addr   (mem_window1_end),
    .addr       (cb_addr),
    .hit        (cb_hits[1])
  );

  io_window_match u_cb_io0
  (
    .start_addr (io_window0_start),
    .end_addr   (io_window0_end),
    .addr       (cb_addr),
    .hit        (cb_hits[2])
  );

  io_window_match u_cb_io1
  (
    .start_addr (io_window1_start),
    .end_addr   (io_window1_end),
    .addr       (cb_addr),
    .hit        (cb_hits[3])
  );

  assign pci_type_hit = type_hit(pci_is_io, pci_hits);
  assign cb_type_hit  = type_hit(cb_is_io, cb_hits);

  assign next_pci_to_cardbus = pci_valid && pci_type_hit;
  assign next_pci_prefetchable = pci_valid && !pci_is_io &&
    pref_pick(pci_hits[1:0], mem_win0_prefetchable, mem_win1_prefetchable);
  // Cycles outside both windows of their own type go upstream
  assign next_cardbus_to_pci = cb_valid && !cb_type_hit;

  // Registered so decode timing does not depend on register write timing
  always @(posedge clk)
  begin
    if (srst)
    begin
      pci_to_cardbus   <= 1'b0;
      pci_prefetchable <= 1'b0;
      cardbus_to_pci   <= 1'b0;
    end
    else
    begin
      pci_to_cardbus   <= next_pci_to_cardbus;
      pci_prefetchable <= next_pci_prefetchable;
      cardbus_to_pci   <= next_cardbus_to_pci;
    end
  end

endmodule

/* logic/cardbus_window_map.vh */
// Purpose: Register offsets, field layouts and reset values of the window decode
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus
// Notes:   Included by every design file of the window decode
`ifndef CARDBUS_WINDOW_MAP_VH
`define CARDBUS_WINDOW_MAP_VH

`define MEM_WINDOW0_START_OFS 8'h1C
`define MEM_WINDOW0_END_OFS   8'h20
`define MEM_WINDOW1_START_OFS 8'h24
`define MEM_WINDOW1_END_OFS   8'h28
`define IO_WINDOW0_START_OFS  8'h2C
`define IO_WINDOW0_END_OFS    8'h30
`define IO_WINDOW1_START_OFS  8'h34
`define IO_WINDOW1_END_OFS    8'h38
`define WINDOW_CTRL_OFS       8'h3C
`define WINDOW_STATUS_OFS     8'h40

`define MEM_WR_MASK           32'hFFFFF000
`define MEM_LOW_ONES          32'h00000FFF
`define IO_START_WR_MASK      32'hFFFFFFFC
`define IO_END_WR_MASK        32'h0000FFFC
`define IO_LOW_ONES           32'h00000003
`define IO_PAGE_MASK          32'hFFFF0000
`define IO_OFFSET_MASK        32'h0000FFFF
`define WINDOW_RESET          32'h00000000

`define CTRL_MEM_WIN0_PREFETCHABLE_BIT    8
`define CTRL_MEM_WIN1_PREFETCHABLE_BIT    9
`define CTRL_RESET            32'h00000300
`define CTRL_WR_MASK          32'h00000300

`endif

/* logic/mem_window_match.v */
// Purpose: Hit test of one memory window
// Assumes: Start and end hold zeros below bit 12
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "cardbus_window_map.vh"

module mem_window_match
(
  input  wire [31:0] start_addr,
  input  wire [31:0] end_addr,
  input  wire [31:0] addr,
  output wire        hit
);

  wire enabled;
  wire [31:0] top;

  assign enabled = (start_addr != `WINDOW_RESET) || (end_addr != `WINDOW_RESET);
  assign top = end_addr | `MEM_LOW_ONES;
  assign hit = enabled && (addr >= start_addr) && (addr <= top);

endmodule

/* logic/io_window_match.v */
// Purpose: Hit test of one I/O window
// Assumes: The page of the window comes from the start register alone
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "cardbus_window_map.vh"

module io_window_match
(
  input  wire [31:0] start_addr,
  input  wire [31:0] end_addr,
  input  wire [31:0] addr,
  output wire        hit
);

  wire enabled;
  wire [31:0] top;

  assign enabled = (start_addr != `WINDOW_RESET) || (end_addr != `WINDOW_RESET);
  assign top = (start_addr & `IO_PAGE_MASK) | (end_addr & `IO_OFFSET_MASK) | `IO_LOW_ONES;
  assign hit = enabled && (addr >= start_addr) && (addr <= top);

endmodule

/* bench/cardbus_window_props.sv */
// Purpose: Port checker of the window decode
// Assumes: Zero wait slave, read data loaded at the address edge
// Notes:   Decode outputs lag their request by one edge
`timescale 1ns/1ps
module cardbus_window_props
(
  input wire        clk,
  input wire        srst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        pci_valid,
  input wire        pci_is_io,
  input wire        pci_to_cardbus,
  input wire        pci_prefetchable,
  input wire        cb_valid,
  input wire        cardbus_to_pci
);
  default clocking main_clk @(posedge clk); endclocking
  default disable iff (srst);
  wire       take = hsel && hready && htrans[1] && !hwrite;
  wire [7:0] ofs  = haddr[7:0];
  AST_RST_CLEAR: assert property ($past(srst) |-> !pci_to_cardbus && !cardbus_to_pci)
    else $error("decode not cleared by reset");
  AST_P2C_CAUSE: assert property (!$past(pci_valid) |-> !pci_to_cardbus)
    else $error("forward without a request");
  AST_C2P_CAUSE: assert property (!$past(cb_valid) |-> !cardbus_to_pci)
    else $error("upstream forward without a cycle");
  AST_PREF_HIT: assert property (pci_prefetchable |-> pci_to_cardbus)
    else $error("prefetchable without a hit");
  AST_PREF_MEM: assert property ($past(pci_is_io) |-> !pci_prefetchable)
    else $error("prefetchable on an io cycle");
  AST_MEM_LOW: assert property (take && ofs inside {8'h1C, 8'h20, 8'h24, 8'h28}
    |=> hrdata[11:0] == 12'h000)
    else $error("memory window low bits not zero");
  AST_IOS_LOW: assert property (take && ofs inside {8'h2C, 8'h34} |=> hrdata[1:0] == 2'h0)
    else $error("io start low bits not zero");
  AST_IOE_RO: assert property (take && ofs inside {8'h30, 8'h38}
    |=> hrdata[31:16] == 16'h0000 && hrdata[1:0] == 2'h0)
    else $error("io end read-only bits not zero");
  AST_UNMAPPED: assert property (take && ofs == 8'h44 |=> hrdata == 32'h00000000)
    else $error("unmapped offset not zero");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered an error");
  cover property (pci_to_cardbus);
  cover property (pci_prefetchable);
  cover property (cardbus_to_pci);
endmodule
bind cardbus_window_decode cardbus_window_props chk (.*);

/* bench/bridge_far_side.sv */
// Purpose: Far side model issuing PCI and CardBus cycles
// Assumes: Bench seeds the random source once
// Notes:   Idle addresses keep moving so stale use shows
`timescale 1ns/1ps
module bridge_far_side
(
  input  wire        clk,
  input  wire        run,
  input  wire [31:0] near,
  output reg         pci_valid = 1'b0,
  output reg         pci_is_io = 1'b0,
  output reg  [31:0] pci_addr  = 32'h00000000,
  output reg         cb_valid  = 1'b0,
  output reg         cb_is_io  = 1'b0,
  output reg  [31:0] cb_addr   = 32'h00000000
);
  // Addresses straddle a bound to hit both sides of it
  always @(posedge clk)
  begin
    pci_valid <= run && ($urandom % 2 != 0);
    pci_is_io <= ($urandom % 2 != 0);
    pci_addr  <= near + $urandom % 32 - 16;
    cb_valid  <= run && ($urandom % 2 != 0);
    cb_is_io  <= ($urandom % 2 != 0);
    cb_addr   <= near + $urandom % 32 - 16;
  end
endmodule

/* bench/cardbus_window_decode_test.sv */
// Purpose: Self-checking bench of the window decode
// Assumes: Zero wait AHB-Lite slave
// Notes:   Decode compared on the falling edge
`timescale 1ns/1ps
module cardbus_window_decode_test;
  reg         clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, near = 32'h0, r, qa, qc;
  reg  [1:0]  htrans = 2'h0;
  reg  [7:0]  st = 8'h00;
  reg         qv, qio, qcv, qcio, qrun = 1'b0;
  reg  [31:0] sh [0:8];
  wire        hrdy, hresp, p2c, pref, c2p, pv, pio, cv, cio;
  wire [31:0] hrdata, pa, ca;
  integer     n_fail = 0, checks_done = 0, cyc = 0, i, k;
  initial forever #2 clk = ~clk;
  cardbus_window_decode dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .pci_valid(pv), .pci_is_io(pio),
    .pci_addr(pa), .pci_to_cardbus(p2c), .pci_prefetchable(pref), .cb_valid(cv),
    .cb_is_io(cio), .cb_addr(ca), .cardbus_to_pci(c2p));
  bridge_far_side far (.clk(clk), .run(run), .near(near), .pci_valid(pv), .pci_is_io(pio),
    .pci_addr(pa), .cb_valid(cv), .cb_is_io(cio), .cb_addr(ca));
  function hit(input io, input [31:0] s, input [31:0] e, input [31:0] a);
    hit = (s != 0 || e != 0) && a >= s && a <= (io ? {s[31:16], e[15:0]} | 32'h3 : e | 32'hFFF);
  endfunction
  function [1:0] wins(input io, input [31:0] a);
    wins = {hit(io, sh[io ? 6 : 2], sh[io ? 7 : 3], a), hit(io, sh[io ? 4 : 0], sh[io ? 5 : 1], a)};
  endfunction
  function pf(input [31:0] a);
    reg [1:0] w;
    w = wins(1'b0, a);
    pf = w[0] ? sh[8][8] : w[1] & sh[8][9];
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task ahb(input is_wr, input integer i, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= is_wr;
    haddr <= 32'h1C + 4 * i;
    do @(posedge clk); while (hrdy !== 1'b1);
    // Far side addresses as the slave sees them at its address edge
    st = {wins(1'b1, ca), wins(1'b0, ca), wins(1'b1, pa), wins(1'b0, pa)};
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task wr(input integer i, input [31:0] d);
    ahb(1'b1, i, d);
    if (i < 9)
      sh[i] = d & (i < 4 ? 32'hFFFFF000 : i == 8 ? 32'h00000300 : i % 2 ? 32'h0000FFFC : 32'hFFFFFFFC);
  endtask
  task rd(input integer i);
    ahb(1'b0, i, 32'h0);
    check(r, i == 9 ? {24'h0, st} : i < 9 ? sh[i] : 32'h0);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    {qrun, qv, qio, qa, qcv, qcio, qc} <= {run, pv, pio, pa, cv, cio, ca};
    if (cyc == 30000)
    begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  always @(negedge clk)
    if (qrun)
    begin
      check(p2c, qv && |wins(qio, qa));
      check(pref, qv && !qio && pf(qa));
      check(c2p, qcv && !(|wins(qcio, qc)));
    end
  initial
  begin
    i = $urandom(32'hB1BA);
    for (i = 0; i < 9; i = i + 1)
      sh[i] = (i == 8) ? 32'h00000300 : 32'h0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (k = 0; k < 40; k = k + 1)
    begin
      // First round keeps reset values: every window closed
      for (i = 0; i < 9 && k > 0; i = i + 1)
        wr(i, $urandom);
      if (k == 1)
      begin
        wr(0, 32'h0);
        wr(4, 32'h0);
      end
      wr(10, 32'hFFFFFFFF);
      for (i = 0; i < 11; i = i + 1)
        rd(i);
      run <= 1'b1;
      repeat (10)
      begin
        case ($urandom % 3)
          0: near <= sh[$urandom % 8];
          1: near <= sh[$urandom % 4] | 32'hFFF;
          default: near <= {sh[4][31:16], sh[5][15:0] | 16'h3};
        endcase
        repeat (20) @(posedge clk);
      end
      run <= 1'b0;
      repeat (2) @(posedge clk);
    end
    end_sim;
  end
endmodule
